// ===== verilog/gpsm_pkg.sv
// Package: constants and types for the power save state machine
package gpsm_pkg;

	// Power scheme selection
	localparam logic [1:0] GPSM_SCHEME_CONT = 2'h0;
	localparam logic [1:0] GPSM_SCHEME_CYCLIC = 2'h1;
	localparam logic [1:0] GPSM_SCHEME_ONOFF = 2'h2;

	// Cyclic update period limits, seconds
	localparam logic [3:0] GPSM_CYC_PERIOD_MIN = 4'h2;
	localparam logic [3:0] GPSM_CYC_PERIOD_MAX = 4'ha;

	// Tick rates
	localparam int GPSM_CLK_HZ = 25000000;
	localparam int GPSM_HALF_SEC_MS = 500;
	localparam int GPSM_CYC_PER_MS = GPSM_CLK_HZ / 1000;

	// Counter widths and reset values
	localparam int GPSM_TW = 32;
	localparam logic [31:0] GPSM_ZERO32 = 32'h0;
	localparam logic [31:0] GPSM_ONE32 = 32'h1;

	// States of the machine
	typedef enum logic [2:0] {
		GPSM_ST_ACQ,
		GPSM_ST_TRACK,
		GPSM_ST_LEAN,
		GPSM_ST_IDLE_UPD,
		GPSM_ST_IDLE_SRCH,
		GPSM_ST_CFGREAD
	} gpsm_state_t;

	// Configuration carried as one group
	typedef struct packed {
		logic [1:0] power_scheme_select;
		logic pin_force_wake_enable;
		logic pin_force_sleep_enable;
		logic pin_idle_watch_enable;
		logic keep_searching;
		logic [31:0] pin_idle_limit;
		logic [31:0] track_hold_time;
		logic [31:0] fix_interval;
		logic [31:0] retry_interval;
		logic [31:0] schedule_shift;
		logic [31:0] search_time_max;
		logic [31:0] startup_margin;
		logic [3:0] cyclic_period_s;
		logic cyclic_half_sec;
	} gpsm_cfg_t;

	// Status from the navigation engine
	typedef struct packed {
		logic fix_valid;
		logic signal_good;
		logic fix_lost;
	} gpsm_nav_t;

endpackage

// ===== verilog/gpsm_core.sv
// Module: power save state machine of a navigation receiver
// Behaviour
// - Wake option plus high pin: stay awake.
// - Sleep option plus low pin: stay inactive.
// - Idle watch: unchanged pin past limit sleeps.
// - Cyclic rates 1 Hz, 2 Hz, 2..10 s.
// - Power-on always begins in acquisition.
// - Fix goes tracking, else search inactive outside continuous.
// - Cyclic hold expiry with good signal enters lean tracking.
// - Lean tracking keeps producing fixes.
// - Weak signal returns lean to tracking.
// - Cyclic fix loss goes to acquisition.
// - Keep-searching never times out into search inactive.
// - On/off hold expiry: update inactive, grid.
// - On/off signal loss goes to acquisition.
// - Off entry clears volatile configuration.
// - Forced awake limits states; release resumes.
// - Forced sleep wake reads pins, returns.
// - Both options: pin fully controls scheme.
// - Pin control also in continuous scheme.
// - On/off wake restarts fix unless active.
// - Zero period waits for host wake.
// - Wake: rx, ctrl, cs edges; restart rise.
// - Cyclic or on/off acquisition timeout enters search inactive.
`timescale 1ns/1ps
`default_nettype none

module gpsm_core
	import gpsm_pkg::*;
#(
	parameter int TICK_CYCLES = GPSM_CYC_PER_MS
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire gpsm_cfg_t cfg_i,
	input wire gpsm_nav_t nav_i,
	input wire logic external_control_pin_i,
	input wire logic serial_rx_pin_i,
	input wire logic chip_select_pin_i,
	input wire logic hard_restart_pin_i,
	output gpsm_state_t state_o,
	output logic engine_on_o,
	output logic fix_strobe_o,
	output logic volatile_clear_o,
	output logic cfg_pin_read_o
);

	// ********************************************************
	// Pin synchronisers
	// ********************************************************
	logic [3:0] pin_meta_r;
	logic [3:0] pin_sync_r;
	logic [3:0] pin_prev_r;
	logic [3:0] pin_in;
	assign pin_in = {hard_restart_pin_i, chip_select_pin_i, serial_rx_pin_i, external_control_pin_i};

	// Two stages per pin, stage one feeds only stage two
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			pin_meta_r <= 4'h0;
			pin_sync_r <= 4'h0;
			pin_prev_r <= 4'h0;
		end else begin
			pin_meta_r <= pin_in;
			pin_sync_r <= pin_meta_r;
			pin_prev_r <= pin_sync_r;
		end
	end

	logic ctrl_lvl;
	logic [3:0] pin_edge;
	logic wake_evt;
	assign ctrl_lvl = pin_sync_r[0];
	assign pin_edge = pin_sync_r ^ pin_prev_r;
	// Either edge on three pins, rising only on restart
	assign wake_evt = (|pin_edge[2:0]) | (pin_sync_r[3] & ~pin_prev_r[3]);

	// ********************************************************
	// Millisecond tick
	// ********************************************************
	logic [31:0] pre_r;
	logic tick;
	assign tick = (pre_r == 32'(TICK_CYCLES - 1));

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			pre_r <= GPSM_ZERO32;
		end else if (tick) begin
			pre_r <= GPSM_ZERO32;
		end else begin
			pre_r <= pre_r + GPSM_ONE32;
		end
	end

	// Free running ms time base, stands in for the real-time grid
	logic [31:0] now_ms_r;
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			now_ms_r <= GPSM_ZERO32;
		end else if (tick) begin
			now_ms_r <= now_ms_r + GPSM_ONE32;
		end
	end

	// ********************************************************
	// Pin idle watch
	// ********************************************************
	logic [31:0] idle_ms_r;
	logic pin_idle;
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			idle_ms_r <= GPSM_ZERO32;
		end else if (pin_edge[0]) begin
			idle_ms_r <= GPSM_ZERO32;
		end else if (tick && !pin_idle) begin
			idle_ms_r <= idle_ms_r + GPSM_ONE32;
		end
	end
	assign pin_idle = cfg_i.pin_idle_watch_enable && (idle_ms_r > cfg_i.pin_idle_limit);

	// Pin overrides, applied in every scheme including continuous
	logic force_wake;
	logic force_sleep;
	assign force_wake = cfg_i.pin_force_wake_enable && ctrl_lvl;
	assign force_sleep = (cfg_i.pin_force_sleep_enable && !ctrl_lvl) || pin_idle;

	// ********************************************************
	// Fix cadence for cyclic and lean tracking
	// ********************************************************
	logic [31:0] fix_period_ms;
	logic [3:0] cyc_s;
	always_comb begin
		cyc_s = cfg_i.cyclic_period_s;
		if (cyc_s < GPSM_CYC_PERIOD_MIN) begin
			cyc_s = GPSM_CYC_PERIOD_MIN;
		end
		if (cyc_s > GPSM_CYC_PERIOD_MAX) begin
			cyc_s = GPSM_CYC_PERIOD_MAX;
		end
		if (cfg_i.cyclic_half_sec) begin
			fix_period_ms = 32'(GPSM_HALF_SEC_MS);
		end else if (cfg_i.cyclic_period_s <= 4'h1) begin
			fix_period_ms = 32'(2 * GPSM_HALF_SEC_MS);
		end else begin
			fix_period_ms = 32'(cyc_s) * 32'(2 * GPSM_HALF_SEC_MS);
		end
	end

	// ********************************************************
	// State machine
	// ********************************************************
	gpsm_state_t state_r;
	gpsm_state_t state_nxt;
	logic [31:0] t_ms_r;
	logic [31:0] wait_ms_r;
	logic [31:0] wait_nxt;
	logic restart_timer;
	logic is_onoff;
	logic is_cyc;
	logic inactive;
	logic acq_timeout;
	logic hold_done;
	logic [31:0] grid_phase;
	logic [31:0] upd_wait;
	logic [31:0] srch_wait;

	assign is_onoff = cfg_i.power_scheme_select == GPSM_SCHEME_ONOFF;
	assign is_cyc = cfg_i.power_scheme_select == GPSM_SCHEME_CYCLIC;
	assign inactive = (state_r == GPSM_ST_IDLE_UPD) || (state_r == GPSM_ST_IDLE_SRCH);
	assign acq_timeout = (cfg_i.search_time_max != GPSM_ZERO32) && (t_ms_r >= cfg_i.search_time_max);
	assign hold_done = t_ms_r >= cfg_i.track_hold_time;

	// Restart on the update grid; zero interval waits forever
	assign grid_phase = (cfg_i.fix_interval == GPSM_ZERO32) ? GPSM_ZERO32 :
		(now_ms_r - cfg_i.schedule_shift) % cfg_i.fix_interval;
	assign upd_wait = (cfg_i.fix_interval == GPSM_ZERO32) ? GPSM_ZERO32 :
		cfg_i.fix_interval - grid_phase;
	// Margin taken off the search period so the engine is warm on time
	assign srch_wait = (cfg_i.retry_interval > cfg_i.startup_margin) ?
		cfg_i.retry_interval - cfg_i.startup_margin : GPSM_ONE32;

	// Next state decision
	always_comb begin
		state_nxt = state_r;
		wait_nxt = wait_ms_r;
		restart_timer = 1'b0;
		case (state_r)
			GPSM_ST_ACQ: begin
				if (nav_i.fix_valid) begin
					state_nxt = GPSM_ST_TRACK;
					restart_timer = 1'b1;
				end else if (acq_timeout && !cfg_i.keep_searching && !force_wake && !is_cyc_or_off_cont()) begin
					state_nxt = GPSM_ST_IDLE_SRCH;
					wait_nxt = (cfg_i.retry_interval == GPSM_ZERO32) ? GPSM_ZERO32 : srch_wait;
					restart_timer = 1'b1;
				end
			end
			GPSM_ST_TRACK: begin
				if (nav_i.fix_lost) begin
					state_nxt = GPSM_ST_ACQ;
					restart_timer = 1'b1;
				end else if (hold_done && nav_i.signal_good && is_cyc) begin
					state_nxt = GPSM_ST_LEAN;
				end else if (hold_done && is_onoff && !force_wake) begin
					state_nxt = GPSM_ST_IDLE_UPD;
					wait_nxt = upd_wait;
					restart_timer = 1'b1;
				end
			end
			GPSM_ST_LEAN: begin
				if (!nav_i.signal_good || nav_i.fix_lost || !is_cyc) begin
					state_nxt = GPSM_ST_TRACK;
					restart_timer = 1'b1;
				end
			end
			GPSM_ST_IDLE_UPD, GPSM_ST_IDLE_SRCH: begin
				if (force_wake) begin
					state_nxt = GPSM_ST_ACQ;
					restart_timer = 1'b1;
				end else if (wake_evt && force_sleep) begin
					state_nxt = GPSM_ST_CFGREAD;
				end else if (wake_evt || (!force_sleep && wait_ms_r != GPSM_ZERO32 && t_ms_r >= wait_ms_r)) begin
					state_nxt = GPSM_ST_ACQ;
					restart_timer = 1'b1;
				end
			end
			GPSM_ST_CFGREAD: begin
				state_nxt = GPSM_ST_IDLE_SRCH;
				wait_nxt = GPSM_ZERO32;
			end
			default: begin
				state_nxt = GPSM_ST_ACQ;
			end
		endcase
		// Forced sleep overrides awake states unless forced awake
		if (force_sleep && !force_wake && !inactive && state_r != GPSM_ST_CFGREAD) begin
			state_nxt = GPSM_ST_IDLE_SRCH;
			wait_nxt = GPSM_ZERO32;
			restart_timer = 1'b1;
		end
	end

	// Continuous scheme never leaves acquisition on its own
	function automatic logic is_cyc_or_off_cont();
		is_cyc_or_off_cont = (cfg_i.power_scheme_select == GPSM_SCHEME_CONT);
	endfunction

	// State register; reset always lands in acquisition
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			state_r <= GPSM_ST_ACQ;
			wait_ms_r <= GPSM_ZERO32;
		end else begin
			state_r <= state_nxt;
			wait_ms_r <= wait_nxt;
		end
	end

	// State timer in ms, restarted on entry
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			t_ms_r <= GPSM_ZERO32;
		end else if (restart_timer) begin
			t_ms_r <= GPSM_ZERO32;
		end else if (tick && t_ms_r != 32'hffffffff) begin
			t_ms_r <= t_ms_r + GPSM_ONE32;
		end
	end

	// ********************************************************
	// Fix cadence and outputs
	// ********************************************************
	logic [31:0] fix_ms_r;
	logic fix_due;
	assign fix_due = tick && (fix_ms_r + GPSM_ONE32 >= fix_period_ms);
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			fix_ms_r <= GPSM_ZERO32;
		end else if (fix_due || state_r != GPSM_ST_LEAN) begin
			fix_ms_r <= GPSM_ZERO32;
		end else if (tick) begin
			fix_ms_r <= fix_ms_r + GPSM_ONE32;
		end
	end

	// Registered outputs
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			fix_strobe_o <= 1'b0;
			volatile_clear_o <= 1'b0;
			cfg_pin_read_o <= 1'b0;
			engine_on_o <= 1'b1;
		end else begin
			fix_strobe_o <= (state_r == GPSM_ST_LEAN) ? fix_due : (state_r == GPSM_ST_TRACK) && nav_i.fix_valid;
			// Only on/off off-entry wipes volatile state; backed store untouched
			volatile_clear_o <= is_onoff && (state_nxt == GPSM_ST_IDLE_UPD || state_nxt == GPSM_ST_IDLE_SRCH)
				&& !inactive;
			cfg_pin_read_o <= state_nxt == GPSM_ST_CFGREAD;
			engine_on_o <= !(state_nxt == GPSM_ST_IDLE_UPD || state_nxt == GPSM_ST_IDLE_SRCH);
		end
	end
	assign state_o = state_r;

	// ********************************************************
	// Assertions
	// ********************************************************
	a_wake_stays_awake: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		force_wake |=> !(state_r == GPSM_ST_IDLE_UPD || state_r == GPSM_ST_IDLE_SRCH) || $past(inactive))
		else $error("entered inactive while forced awake");
	a_sleep_goes_idle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(force_sleep && !force_wake && (state_r == GPSM_ST_TRACK)) |=> state_r == GPSM_ST_IDLE_SRCH)
		else $error("forced sleep ignored");
	a_keep_search_acq: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(cfg_i.keep_searching && !force_sleep && state_r == GPSM_ST_ACQ) |=> state_r != GPSM_ST_IDLE_SRCH)
		else $error("search inactive despite keep searching");
	a_fix_to_track: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(state_r == GPSM_ST_ACQ && nav_i.fix_valid && !force_sleep) |=> state_r == GPSM_ST_TRACK)
		else $error("fix did not enter tracking");
	a_lean_weak_back: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(state_r == GPSM_ST_LEAN && !nav_i.signal_good && !force_sleep) |=> state_r == GPSM_ST_TRACK)
		else $error("lean did not return to tracking");
	a_cfgread_returns: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		state_r == GPSM_ST_CFGREAD |=> state_r == GPSM_ST_IDLE_SRCH ##0 cfg_pin_read_o == 1'b0)
		else $error("config read did not return inactive");
	a_track_loss_acq: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(state_r == GPSM_ST_TRACK && nav_i.fix_lost && !force_sleep) |=> state_r == GPSM_ST_ACQ)
		else $error("signal loss did not enter acquisition");
	a_active_wake_noop: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(state_r == GPSM_ST_LEAN && wake_evt && nav_i.signal_good && !nav_i.fix_lost && is_cyc && !force_sleep)
		|=> state_r == GPSM_ST_LEAN)
		else $error("wake disturbed active state");
	a_onoff_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(is_onoff && state_r == GPSM_ST_TRACK && state_nxt == GPSM_ST_IDLE_UPD) |=> volatile_clear_o)
		else $error("off entry did not clear volatile memory");

	c_lean_reached: cover property (@(posedge clk_i) state_r == GPSM_ST_LEAN);
	c_update_idle: cover property (@(posedge clk_i) state_r == GPSM_ST_IDLE_UPD);
	c_cfg_read: cover property (@(posedge clk_i) state_r == GPSM_ST_CFGREAD);
	c_search_idle: cover property (@(posedge clk_i) state_r == GPSM_ST_IDLE_SRCH ##1 state_r == GPSM_ST_ACQ);

endmodule

`default_nettype wire

// ===== test/gpsm_host.sv
// Host model that drives the control pin and the wake source pins
`timescale 1ns/1ps
`default_nettype none

module gpsm_host (
	input wire logic clk_i,
	output logic ctrl_pin_o,
	output logic rx_pin_o,
	output logic cs_pin_o,
	output logic restart_pin_o
);
	// ************************************************************
	// Pin drivers
	// ************************************************************

	// All pins start low so a reset release raises no wake event
	initial begin
		ctrl_pin_o = 1'b0;
		rx_pin_o = 1'b0;
		cs_pin_o = 1'b0;
		restart_pin_o = 1'b0;
	end

	// Return every pin to low before a reset, so release shows no false edge
	task automatic rest;
		@(posedge clk_i);
		ctrl_pin_o <= 1'b0;
		rx_pin_o <= 1'b0;
		cs_pin_o <= 1'b0;
		restart_pin_o <= 1'b0;
	endtask

	// Host owns the control pin level
	task automatic set_ctrl(input logic v);
		@(posedge clk_i);
		ctrl_pin_o <= v;
	endtask

	// One wake event: 0 rx edge, 1 cs edge, 2 ctrl edge, else restart pulse
	task automatic wake(input int src);
		@(posedge clk_i);
		case (src)
			0: rx_pin_o <= ~rx_pin_o;
			1: cs_pin_o <= ~cs_pin_o;
			2: ctrl_pin_o <= ~ctrl_pin_o;
			default: begin
				// Short pulse: task returns before the synced rise is acted on
				restart_pin_o <= 1'b1;
				@(posedge clk_i);
				restart_pin_o <= 1'b0; // Falling edge must not count as wake
			end
		endcase
	endtask
endmodule

`default_nettype wire

// ===== test/gpsm_core_bench.sv
// Self-checking testbench for the power save state machine
`timescale 1ns/1ps
`default_nettype none

module gpsm_core_bench;
	import gpsm_pkg::*;
	// ************************************************************
	// Signals and instances
	// ************************************************************
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	gpsm_cfg_t cfg;
	gpsm_nav_t nav;
	logic ctrl_pin, rx_pin, cs_pin, restart_pin;
	gpsm_state_t state;
	logic engine_on, fix_strobe, vol_clear, pin_read;
	int num_errors = 0;
	int checked = 0;

	gpsm_host gpsm_host_i (.clk_i(clk), .ctrl_pin_o(ctrl_pin), .rx_pin_o(rx_pin),
		.cs_pin_o(cs_pin), .restart_pin_o(restart_pin));

	// Short ms tick: 4 cycles per ms keeps every timer tiny
	gpsm_core #(.TICK_CYCLES(4)) gpsm_core_i (.clk_i(clk), .reset_n_i(reset_n), .cfg_i(cfg),
		.nav_i(nav), .external_control_pin_i(ctrl_pin), .serial_rx_pin_i(rx_pin),
		.chip_select_pin_i(cs_pin), .hard_restart_pin_i(restart_pin), .state_o(state),
		.engine_on_o(engine_on), .fix_strobe_o(fix_strobe), .volatile_clear_o(vol_clear),
		.cfg_pin_read_o(pin_read));

	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [7:0] probe(input int w);
		case (w)
			0: return {5'h0, state};
			1: return {7'h0, fix_strobe};
			default: return {7'h0, pin_read};
		endcase
	endfunction

	// Bounded wait; pulses are looked at in the cycle they stand
	task automatic wait_for(input int w, input logic [7:0] v, input int limit);
		int i;
		i = 0;
		while (i < limit && probe(w) !== v) begin
			@(posedge clk);
			#1;
			i++;
		end
		check(probe(w), v);
	endtask

	// Flags are {wake, sleep, idle watch, keep searching}
	task automatic start(input logic [1:0] scheme, input logic [3:0] f);
		gpsm_host_i.rest();
		@(posedge clk);
		reset_n <= 1'b0;
		nav <= '0;
		cfg.pin_force_wake_enable <= f[3];
		cfg.pin_force_sleep_enable <= f[2];
		cfg.pin_idle_watch_enable <= f[1];
		cfg.keep_searching <= f[0];
		cfg.power_scheme_select <= scheme; // Scheme goes last
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		#1;
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_cyclic;
		start(GPSM_SCHEME_CYCLIC, 4'h0);
		check({5'h0, state}, {5'h0, GPSM_ST_ACQ});
		@(posedge clk) nav <= 3'b110;
		wait_for(0, {5'h0, GPSM_ST_TRACK}, 10);
		@(posedge clk) nav.fix_valid <= 1'b0;
		wait_for(0, {5'h0, GPSM_ST_LEAN}, 40);
		wait_for(1, 8'h1, 2500);
		@(posedge clk) nav.signal_good <= 1'b0;
		wait_for(0, {5'h0, GPSM_ST_TRACK}, 10);
		@(posedge clk) nav.fix_lost <= 1'b1;
		wait_for(0, {5'h0, GPSM_ST_ACQ}, 10);
		@(posedge clk) nav.fix_lost <= 1'b0;
		wait_for(0, {5'h0, GPSM_ST_IDLE_SRCH}, 40);
		repeat (100) @(posedge clk);
		#1;
		check({5'h0, state}, {5'h0, GPSM_ST_IDLE_SRCH});
		check({7'h0, engine_on}, 8'h0);
	endtask

	task automatic t_keep;
		start(GPSM_SCHEME_CYCLIC, 4'h1);
		repeat (100) @(posedge clk);
		#1;
		check({5'h0, state}, {5'h0, GPSM_ST_ACQ});
	endtask

	task automatic t_onoff;
		start(GPSM_SCHEME_ONOFF, 4'h0);
		@(posedge clk) nav <= 3'b110;
		wait_for(0, {5'h0, GPSM_ST_TRACK}, 10);
		@(posedge clk) nav <= 3'b011;
		wait_for(0, {5'h0, GPSM_ST_ACQ}, 10);
		@(posedge clk) nav <= 3'b110;
		wait_for(0, {5'h0, GPSM_ST_TRACK}, 10);
		@(posedge clk) nav.fix_valid <= 1'b0;
		wait_for(0, {5'h0, GPSM_ST_IDLE_UPD}, 40);
		check({7'h0, vol_clear}, 8'h1);
		repeat (60) @(posedge clk);
		#1;
		check({5'h0, state}, {5'h0, GPSM_ST_IDLE_UPD});
		gpsm_host_i.wake(0);
		wait_for(0, {5'h0, GPSM_ST_ACQ}, 10);
		gpsm_host_i.wake(1);
		repeat (6) @(posedge clk);
		#1;
		check({5'h0, state}, {5'h0, GPSM_ST_ACQ});
	endtask

	// Forced sleep in the continuous scheme, woken by rx, cs and restart sources
	task automatic t_sleep;
		int k;
		start(GPSM_SCHEME_CONT, 4'h4);
		wait_for(0, {5'h0, GPSM_ST_IDLE_SRCH}, 10);
		for (k = 0; k < 5; k++) begin
			gpsm_host_i.wake(k < 2 ? 0 : (k < 4 ? 1 : 3));
			wait_for(2, 8'h1, 10);
			wait_for(0, {5'h0, GPSM_ST_IDLE_SRCH}, 10);
		end
	endtask

	// Both pin options: the pin alone decides awake or inactive
	task automatic t_wake;
		int k, low;
		low = 0;
		start(GPSM_SCHEME_ONOFF, 4'hc);
		gpsm_host_i.set_ctrl(1'b1);
		// Pin needs the synchroniser delay before it forces the wake
		repeat (4) @(posedge clk);
		for (k = 0; k < 80; k++) begin
			@(posedge clk);
			#1;
			low += (engine_on !== 1'b1 || state === GPSM_ST_LEAN);
		end
		check(low[7:0], 8'h0);
		gpsm_host_i.set_ctrl(1'b0);
		wait_for(0, {5'h0, GPSM_ST_IDLE_SRCH}, 10);
		gpsm_host_i.set_ctrl(1'b1);
		wait_for(0, {5'h0, GPSM_ST_ACQ}, 10);
		gpsm_host_i.set_ctrl(1'b0);
	endtask

	// Idle watch: toggling keeps it awake, silence past 5 ms sleeps
	task automatic t_idle;
		int k;
		start(GPSM_SCHEME_CYCLIC, 4'h3);
		for (k = 0; k < 10; k++) begin
			gpsm_host_i.wake(2);
			repeat (8) @(posedge clk);
		end
		#1;
		check({7'h0, engine_on}, 8'h1);
		wait_for(0, {5'h0, GPSM_ST_IDLE_SRCH}, 60);
	endtask

	// Timed paths: 1 Hz lean cadence, search retry less margin, update grid
	task automatic t_timed;
		int n;
		@(posedge clk);
		cfg.cyclic_half_sec <= 1'b0;
		cfg.cyclic_period_s <= 4'h1;
		cfg.retry_interval <= 32'ha;
		cfg.startup_margin <= 32'h4;
		cfg.fix_interval <= 32'h14;
		cfg.schedule_shift <= 32'h3;
		start(GPSM_SCHEME_CYCLIC, 4'h0);
		@(posedge clk) nav <= 3'b110;
		wait_for(0, {5'h0, GPSM_ST_TRACK}, 10);
		@(posedge clk) nav.fix_valid <= 1'b0;
		wait_for(0, {5'h0, GPSM_ST_LEAN}, 40);
		n = 0;
		while (n < 4100 && fix_strobe !== 1'b1) begin
			@(posedge clk);
			#1;
			n++;
		end
		// 1000 ms at 4 cycles per ms, tick phase gives a few cycles of slack
		check({7'h0, (n >= 3990 && n <= 4010)}, 8'h1);
		@(posedge clk) nav <= 3'b001;
		wait_for(0, {5'h0, GPSM_ST_IDLE_SRCH}, 40);
		repeat (16) @(posedge clk);
		#1;
		check({5'h0, state}, {5'h0, GPSM_ST_IDLE_SRCH});
		wait_for(0, {5'h0, GPSM_ST_ACQ}, 20);
		start(GPSM_SCHEME_ONOFF, 4'h0);
		@(posedge clk) nav <= 3'b110;
		wait_for(0, {5'h0, GPSM_ST_TRACK}, 10);
		@(posedge clk) nav.fix_valid <= 1'b0;
		wait_for(0, {5'h0, GPSM_ST_IDLE_UPD}, 40);
		wait_for(0, {5'h0, GPSM_ST_ACQ}, 100);
	endtask

	// ************************************************************
	// Clock, sequence, watchdog and verdict
	// ************************************************************
	task automatic final_report;
		if (num_errors == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		forever #20 clk = ~clk;
	end

	// Retry and update intervals stay zero until t_timed, so inactive states wait for the host
	initial begin
		cfg = '0;
		nav = '0;
		cfg.track_hold_time = 32'h3;
		cfg.search_time_max = 32'h5;
		cfg.pin_idle_limit = 32'h5;
		cfg.cyclic_half_sec = 1'b1;
		t_cyclic();
		t_keep();
		t_onoff();
		t_sleep();
		t_wake();
		t_idle();
		t_timed();
		final_report();
	end

	// Whole run needs about 7000 cycles
	initial begin
		#(40 * 20000);
		num_errors++;
		final_report();
	end
endmodule

`default_nettype wire
